// file: esm_pkg.sv
// Purpose: Shared constants for the excitation source and stability monitor
// Assumes: Register indices are the fieldbus object indices
// Notes: Amplitudes and the current command are signed milliamperes; thresholds and peak currents are unsigned milliamperes
package esm_pkg;
  // Register indices
  localparam logic [15:0] IDX_UPDATE_INTERVAL = 16'h0026;
  localparam logic [15:0] IDX_SINE_FREQ = 16'h0028;
  localparam logic [15:0] IDX_CUR_AMP = 16'h002a;
  localparam logic [15:0] IDX_INJECT_POINT = 16'h002c;
  localparam logic [15:0] IDX_MODE = 16'h002e;
  localparam logic [15:0] IDX_WATCHDOG_TIME = 16'h0030;
  localparam logic [15:0] IDX_PRB_DEPTH = 16'h0032;
  localparam logic [15:0] IDX_VEL_AMP = 16'h0034;
  localparam logic [15:0] IDX_FAULT_LIMIT = 16'h0510;
  localparam logic [15:0] IDX_FAULT_THRESH = 16'h0512;
  localparam logic [15:0] IDX_FAULT_STATUS = 16'h0600;
  // Mode and injection point codes
  typedef enum logic [7:0] {
    MODE_NONE = 8'h00, MODE_PRB = 8'h01, MODE_SINE = 8'h02,
    MODE_NOISE = 8'h03, MODE_OFFSET = 8'h04, MODE_STABILITY = 8'h05
  } esm_mode_type;
  localparam logic [7:0] INJ_NONE = 8'h00;
  localparam logic [7:0] INJ_CURRENT = 8'h01;
  localparam logic [7:0] INJ_VELOCITY = 8'h02;
  // Reset values and ranges
  localparam logic [31:0] RST_CUR_AMP = 32'h0000_00c8;
  localparam logic [7:0] RST_UPDATE_INTERVAL = 8'h01;
  localparam logic [7:0] PRB_DEPTH_MIN = 8'h04;
  localparam logic [7:0] PRB_DEPTH_MAX = 8'h13;
  localparam logic [31:0] SINE_FREQ_MAX_HZ = 32'h0000_1f40;
  localparam logic [31:0] FAULT_LIMIT_MIN_MS = 32'h0000_0001;
  localparam logic [31:0] FAULT_LIMIT_MAX_MS = 32'h0000_ea60;
  localparam logic [31:0] FAULT_THRESH_MIN_MA = 32'h0000_0001;
  localparam logic [31:0] SAMPLE_RATE_HZ = 32'h0000_3e80;
  localparam int SINE_STEPS = 64;
  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int SAMPLE_HZ = 16_000;
  localparam int MS_PER_S = 1_000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
endpackage : esm_pkg

// file: esm_excitation.sv
// Contract
// - In mode 5, accumulate time the current command stays above the threshold.
// - Raise instability fault when accumulated time reaches the duration limit.
// - Threshold accepts 0.001 A up to the lower peak current; resets to zero.
// - Injection point 0 none, 1 current, 2 velocity; resets to 0.
// - Mode 0 switches all excitation output off.
// - Mode 1 outputs plus or minus peak amplitude, only phase varies.
// - Binary sequence repeats after two to the depth, times update interval, samples.
// - Noise mode outputs random values within plus and minus peak amplitude.
// - Mode 4 applies constant torque offset equal to current amplitude.
// - Peak amplitude comes from current or velocity amplitude per injection point.
// - Watchdog time 0 leaves mode unchanged indefinitely.
// - Nonzero watchdog time returns mode to 0 after that many milliseconds.
// - Nonzero mode write while mode nonzero restarts the watchdog timer.
// - Sine frequency held in hertz, range 0 to 8000.
// - Fault duration limit held in milliseconds, range 0.001 to 60 seconds.
// - Sequence depth accepts 4 to 19, default 19.
// - Excitation updates once every n drive samples at 16 kHz.
//
// Purpose: Excitation source with watchdog and stability test for a servo drive
// Assumes: Register port writes and reads are one-cycle strobes; currents in mA
// Notes: Excitation outputs recompute every cycle from the waveform held since the last update
`timescale 1ns/1ns
module esm_excitation #(
  parameter int SAMPLE_CYCLES = esm_pkg::SAMPLE_CYCLES,
  parameter int MS_CYCLES = esm_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  output logic reg_rd_valid_ff,
  // Drive status
  input wire logic link_up,
  input wire logic signed [31:0] current_loop_command,
  input wire logic [31:0] drive_peak_current,
  input wire logic [31:0] motor_peak_current,
  // Excitation and fault
  output logic signed [31:0] exc_current_ff,
  output logic signed [31:0] exc_velocity_ff,
  output logic instability_fault_ff
);
  logic [7:0] injection_point_select_ff;
  logic [7:0] excitation_mode_select_ff;
  logic [31:0] current_fault_threshold_ff;
  logic [31:0] current_fault_duration_limit_ff;
  logic [31:0] excitation_watchdog_time_ff;
  logic signed [31:0] current_excitation_amplitude_ff;
  logic signed [31:0] velocity_excitation_amplitude_ff;
  logic [7:0] pseudo_random_sequence_depth_ff;
  logic [7:0] excitation_update_interval_ff;
  logic [31:0] sine_excitation_frequency_ff;
  logic [31:0] samp_cnt_ff;
  logic samp_tick_ff;
  logic [31:0] ms_cnt_ff;
  logic ms_tick_ff;
  logic [7:0] gap_cnt_ff;
  logic upd_tick;
  logic [31:0] wd_cnt_ff;
  logic [31:0] acc_ff;
  logic [18:0] prb_ff;
  logic [31:0] noise_ff;
  logic [31:0] phase_ff;
  logic signed [15:0] wave_ff;
  logic [31:0] peak_min;
  logic [31:0] cmd_abs;
  logic above;
  logic wr_mode;
  logic signed [31:0] amp;
  logic signed [31:0] nxt_val;
  logic signed [47:0] scaled;
  logic [5:0] sine_idx;
  logic [18:0] prb_mask;

  function automatic logic [18:0] prb_taps(input logic [7:0] depth);
    unique case (depth)
      8'h04: prb_taps = 19'h0000c;
      8'h05: prb_taps = 19'h00014;
      8'h06: prb_taps = 19'h00030;
      8'h07: prb_taps = 19'h00060;
      8'h08: prb_taps = 19'h000b8;
      8'h09: prb_taps = 19'h00110;
      8'h0a: prb_taps = 19'h00240;
      8'h0b: prb_taps = 19'h00500;
      8'h0c: prb_taps = 19'h00829;
      8'h0d: prb_taps = 19'h0100d;
      8'h0e: prb_taps = 19'h02015;
      8'h0f: prb_taps = 19'h06000;
      8'h10: prb_taps = 19'h0d008;
      8'h11: prb_taps = 19'h12000;
      8'h12: prb_taps = 19'h20400;
      default: prb_taps = 19'h40023;
    endcase
  endfunction : prb_taps

  function automatic logic signed [15:0] quarter_sine(input logic [4:0] k);
    unique case (k)
      5'h00: quarter_sine = 16'sh0000;
      5'h01: quarter_sine = 16'sh0c8c;
      5'h02: quarter_sine = 16'sh18f9;
      5'h03: quarter_sine = 16'sh2528;
      5'h04: quarter_sine = 16'sh30fb;
      5'h05: quarter_sine = 16'sh3c56;
      5'h06: quarter_sine = 16'sh471c;
      5'h07: quarter_sine = 16'sh5133;
      5'h08: quarter_sine = 16'sh5a82;
      5'h09: quarter_sine = 16'sh62f1;
      5'h0a: quarter_sine = 16'sh6a6d;
      5'h0b: quarter_sine = 16'sh70e2;
      5'h0c: quarter_sine = 16'sh7641;
      5'h0d: quarter_sine = 16'sh7a7c;
      5'h0e: quarter_sine = 16'sh7d89;
      5'h0f: quarter_sine = 16'sh7f61;
      default: quarter_sine = 16'sh7fff;
    endcase
  endfunction : quarter_sine

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  assign peak_min = (drive_peak_current < motor_peak_current) ? drive_peak_current : motor_peak_current;
  assign cmd_abs = current_loop_command[31] ? 32'(-current_loop_command) : current_loop_command;
  assign above = cmd_abs > current_fault_threshold_ff;
  assign wr_mode = reg_wr && (reg_addr == esm_pkg::IDX_MODE) && (reg_wdata <= 32'(esm_pkg::MODE_STABILITY));
  assign upd_tick = samp_tick_ff && (gap_cnt_ff + 8'h01 >= excitation_update_interval_ff);
  assign prb_mask = 19'((20'h00001 << pseudo_random_sequence_depth_ff) - 20'h00001);
  assign sine_idx = 6'((phase_ff * 32'(esm_pkg::SINE_STEPS)) / esm_pkg::SAMPLE_RATE_HZ);

  // Parameter registers; out-of-range values are clamped, illegal codes and a zero update interval ignored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      injection_point_select_ff <= esm_pkg::INJ_NONE;
      current_fault_threshold_ff <= 32'h0000_0000;
      current_fault_duration_limit_ff <= 32'h0000_0000;
      excitation_watchdog_time_ff <= 32'h0000_0000;
      current_excitation_amplitude_ff <= esm_pkg::RST_CUR_AMP;
      velocity_excitation_amplitude_ff <= 32'h0000_0000;
      pseudo_random_sequence_depth_ff <= esm_pkg::PRB_DEPTH_MAX;
      excitation_update_interval_ff <= esm_pkg::RST_UPDATE_INTERVAL;
      sine_excitation_frequency_ff <= 32'h0000_0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        esm_pkg::IDX_INJECT_POINT: begin
          if (reg_wdata <= 32'(esm_pkg::INJ_VELOCITY)) begin
            injection_point_select_ff <= reg_wdata[7:0];
          end
        end
        esm_pkg::IDX_FAULT_THRESH:
          current_fault_threshold_ff <= clamp(reg_wdata, esm_pkg::FAULT_THRESH_MIN_MA, peak_min);
        esm_pkg::IDX_FAULT_LIMIT:
          current_fault_duration_limit_ff <= clamp(reg_wdata, esm_pkg::FAULT_LIMIT_MIN_MS,
                                                   esm_pkg::FAULT_LIMIT_MAX_MS);
        esm_pkg::IDX_WATCHDOG_TIME: excitation_watchdog_time_ff <= reg_wdata;
        esm_pkg::IDX_CUR_AMP: current_excitation_amplitude_ff <= reg_wdata;
        esm_pkg::IDX_VEL_AMP: velocity_excitation_amplitude_ff <= reg_wdata;
        esm_pkg::IDX_PRB_DEPTH:
          pseudo_random_sequence_depth_ff <= 8'(clamp(reg_wdata, 32'(esm_pkg::PRB_DEPTH_MIN),
                                                      32'(esm_pkg::PRB_DEPTH_MAX)));
        esm_pkg::IDX_UPDATE_INTERVAL: begin
          if (reg_wdata[7:0] != 8'h00) begin
            excitation_update_interval_ff <= reg_wdata[7:0];
          end
        end
        esm_pkg::IDX_SINE_FREQ:
          sine_excitation_frequency_ff <= clamp(reg_wdata, 32'h0000_0000, esm_pkg::SINE_FREQ_MAX_HZ);
        default: ;
      endcase
    end
  end

  // Mode with link loss, host write and watchdog, in that priority
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      excitation_mode_select_ff <= esm_pkg::MODE_NONE;
    end else if (!link_up) begin
      excitation_mode_select_ff <= esm_pkg::MODE_NONE;
    end else if (wr_mode) begin
      excitation_mode_select_ff <= reg_wdata[7:0];
    end else if (excitation_watchdog_time_ff != 32'h0000_0000 && ms_tick_ff
                 && wd_cnt_ff + 32'h0000_0001 >= excitation_watchdog_time_ff) begin
      excitation_mode_select_ff <= esm_pkg::MODE_NONE;
    end
  end

  // Watchdog counts milliseconds while excitation is on; any accepted mode write (code 0 to 5) restarts it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wd_cnt_ff <= 32'h0000_0000;
    end else if (wr_mode || excitation_mode_select_ff == esm_pkg::MODE_NONE) begin
      wd_cnt_ff <= 32'h0000_0000;
    end else if (ms_tick_ff && excitation_watchdog_time_ff != 32'h0000_0000) begin
      wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
    end
  end

  // Drive sample and millisecond timebases
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      samp_cnt_ff <= 32'h0000_0000;
      samp_tick_ff <= 1'b0;
      ms_cnt_ff <= 32'h0000_0000;
      ms_tick_ff <= 1'b0;
    end else begin
      samp_tick_ff <= samp_cnt_ff == 32'(SAMPLE_CYCLES - 1);
      samp_cnt_ff <= (samp_cnt_ff == 32'(SAMPLE_CYCLES - 1)) ? 32'h0000_0000 : samp_cnt_ff + 32'h0000_0001;
      ms_tick_ff <= ms_cnt_ff == 32'(MS_CYCLES - 1);
      ms_cnt_ff <= (ms_cnt_ff == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
    end
  end

  // Update interval divider over drive samples
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt_ff <= 8'h00;
    end else if (upd_tick) begin
      gap_cnt_ff <= 8'h00;
    end else if (samp_tick_ff) begin
      gap_cnt_ff <= gap_cnt_ff + 8'h01;
    end
  end

  // Waveform generators advance only on update ticks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prb_ff <= 19'h00001;
      noise_ff <= 32'h1234_5678;
      phase_ff <= 32'h0000_0000;
      wave_ff <= 16'sh0000;
    end else if (upd_tick) begin
      // The all-zero state is spliced into the cycle, so one pass takes two to the depth updates
      prb_ff <= ((prb_ff << 1) | 19'(^(prb_ff & prb_taps(pseudo_random_sequence_depth_ff))
                ^ ((prb_ff & (prb_mask >> 1)) == 19'h00000))) & prb_mask;
      noise_ff <= {noise_ff[30:0], noise_ff[31] ^ noise_ff[21] ^ noise_ff[1] ^ noise_ff[0]};
      phase_ff <= (phase_ff + sine_excitation_frequency_ff * 32'(excitation_update_interval_ff))
                  % esm_pkg::SAMPLE_RATE_HZ;
      unique case (sine_idx[5:4])
        2'b00: wave_ff <= quarter_sine({1'b0, sine_idx[3:0]});
        2'b01: wave_ff <= quarter_sine(5'(5'h10 - {1'b0, sine_idx[3:0]}));
        2'b10: wave_ff <= -quarter_sine({1'b0, sine_idx[3:0]});
        2'b11: wave_ff <= -quarter_sine(5'(5'h10 - {1'b0, sine_idx[3:0]}));
      endcase
    end
  end

  // Selected waveform scaled to the peak amplitude
  always_comb begin
    amp = (injection_point_select_ff == esm_pkg::INJ_CURRENT) ? current_excitation_amplitude_ff
                                                              : velocity_excitation_amplitude_ff;
    scaled = 48'sh0;
    nxt_val = 32'sh0;
    unique case (excitation_mode_select_ff)
      esm_pkg::MODE_PRB: nxt_val = prb_ff[0] ? -amp : amp;
      esm_pkg::MODE_SINE: begin
        scaled = (48'(amp) * 48'(wave_ff)) >>> 15;
        nxt_val = scaled[31:0];
      end
      esm_pkg::MODE_NOISE: begin
        scaled = (48'(amp) * 48'($signed(noise_ff[15:0]))) >>> 15;
        nxt_val = scaled[31:0];
      end
      default: nxt_val = 32'sh0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      exc_current_ff <= 32'sh0;
      exc_velocity_ff <= 32'sh0;
    end else if (excitation_mode_select_ff == esm_pkg::MODE_OFFSET
                 && injection_point_select_ff != esm_pkg::INJ_NONE) begin
      exc_current_ff <= current_excitation_amplitude_ff;
      exc_velocity_ff <= 32'sh0;
    end else begin
      exc_current_ff <= (injection_point_select_ff == esm_pkg::INJ_CURRENT) ? nxt_val : 32'sh0;
      exc_velocity_ff <= (injection_point_select_ff == esm_pkg::INJ_VELOCITY) ? nxt_val : 32'sh0;
    end
  end

  // Stability test accumulator in milliseconds
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= 32'h0000_0000;
    end else if (excitation_mode_select_ff != esm_pkg::MODE_STABILITY) begin
      acc_ff <= 32'h0000_0000;
    end else if (ms_tick_ff && above && acc_ff < current_fault_duration_limit_ff) begin
      acc_ff <= acc_ff + 32'h0000_0001;
    end
  end

  // Sticky fault; a write to the status register clears it, a new event wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instability_fault_ff <= 1'b0;
    end else if (excitation_mode_select_ff == esm_pkg::MODE_STABILITY
                 && current_fault_duration_limit_ff != 32'h0000_0000
                 && acc_ff >= current_fault_duration_limit_ff) begin
      instability_fault_ff <= 1'b1;
    end else if (reg_wr && reg_addr == esm_pkg::IDX_FAULT_STATUS) begin
      instability_fault_ff <= 1'b0;
    end
  end

  // Read port answers one cycle after the strobe; unmapped indices read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 32'h0000_0000;
      reg_rd_valid_ff <= 1'b0;
    end else begin
      reg_rd_valid_ff <= reg_rd;
      unique case (reg_addr)
        esm_pkg::IDX_INJECT_POINT: reg_rdata_ff <= {24'h0, injection_point_select_ff};
        esm_pkg::IDX_MODE: reg_rdata_ff <= {24'h0, excitation_mode_select_ff};
        esm_pkg::IDX_FAULT_THRESH: reg_rdata_ff <= current_fault_threshold_ff;
        esm_pkg::IDX_FAULT_LIMIT: reg_rdata_ff <= current_fault_duration_limit_ff;
        esm_pkg::IDX_WATCHDOG_TIME: reg_rdata_ff <= excitation_watchdog_time_ff;
        esm_pkg::IDX_CUR_AMP: reg_rdata_ff <= current_excitation_amplitude_ff;
        esm_pkg::IDX_VEL_AMP: reg_rdata_ff <= velocity_excitation_amplitude_ff;
        esm_pkg::IDX_PRB_DEPTH: reg_rdata_ff <= {24'h0, pseudo_random_sequence_depth_ff};
        esm_pkg::IDX_UPDATE_INTERVAL: reg_rdata_ff <= {24'h0, excitation_update_interval_ff};
        esm_pkg::IDX_SINE_FREQ: reg_rdata_ff <= sine_excitation_frequency_ff;
        esm_pkg::IDX_FAULT_STATUS: reg_rdata_ff <= {31'h0, instability_fault_ff};
        default: reg_rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence mode_write_s;
    link_up && wr_mode && reg_wdata[7:0] != 8'h00 && excitation_mode_select_ff != 8'h00;
  endsequence

  link_down_a: assert property (!link_up |=> excitation_mode_select_ff == 8'h00)
    else $error("mode not cleared on link loss");
  wd_hold_a: assert property (link_up && !wr_mode && excitation_watchdog_time_ff == 32'h0
    |=> $stable(excitation_mode_select_ff))
    else $error("mode changed with watchdog off");
  wd_expire_a: assert property (link_up && !wr_mode && ms_tick_ff && excitation_watchdog_time_ff != 32'h0
    && wd_cnt_ff + 32'h1 == excitation_watchdog_time_ff |=> excitation_mode_select_ff == 8'h00)
    else $error("watchdog did not expire");
  wd_refresh_a: assert property (mode_write_s |=> wd_cnt_ff == 32'h0 ##1 wd_cnt_ff <= 32'h1)
    else $error("watchdog not restarted");
  acc_clear_a: assert property (excitation_mode_select_ff != 8'h05 |=> acc_ff == 32'h0)
    else $error("accumulator not cleared");
  acc_count_a: assert property (excitation_mode_select_ff == 8'h05 && ms_tick_ff && above
    && acc_ff < current_fault_duration_limit_ff |=> acc_ff == $past(acc_ff) + 32'h1)
    else $error("over-threshold time not counted");
  fault_raise_a: assert property (excitation_mode_select_ff == 8'h05 && current_fault_duration_limit_ff != 32'h0
    && acc_ff >= current_fault_duration_limit_ff |=> instability_fault_ff)
    else $error("instability fault not raised");
  mode_off_a: assert property (excitation_mode_select_ff == 8'h00
    |=> exc_current_ff == 32'sh0 && exc_velocity_ff == 32'sh0)
    else $error("excitation present in mode none");
  prb_level_a: assert property (excitation_mode_select_ff == 8'h01 && injection_point_select_ff == 8'h01
    |=> exc_current_ff == $past(amp) || exc_current_ff == -$past(amp))
    else $error("binary excitation off peak");
  offset_out_a: assert property (excitation_mode_select_ff == 8'h04 && injection_point_select_ff != 8'h00
    |=> exc_current_ff == $past(current_excitation_amplitude_ff))
    else $error("torque offset wrong");
  inj_vel_a: assert property (injection_point_select_ff == 8'h02 |=> exc_current_ff == 32'sh0
    || $past(excitation_mode_select_ff) == 8'h04)
    else $error("current output active at velocity point");
  thresh_range_a: assert property (reg_wr && reg_addr == 16'h0512 |=> current_fault_threshold_ff >= 32'h1
    && current_fault_threshold_ff <= $past(peak_min))
    else $error("threshold out of range");
endmodule : esm_excitation

// file: esm_host_model.sv
// Purpose: Host tuning software model issuing register writes and reads
// Assumes: One-cycle strobes; a read answer stands one edge after the read
// Notes: Released address and data show the inverse of the last value, never a held copy
`timescale 1ns/1ns
module esm_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic reg_rd_valid_ff
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // A missing answer returns all ones so the caller's compare fails
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    d = (reg_rd_valid_ff === 1'b1) ? reg_rdata_ff : 32'hffff_ffff;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : esm_host_model

// file: test_esm_excitation.sv
// Purpose: Self-checking bench for the excitation source and stability monitor
// Assumes: Shortened sample and millisecond periods (4 and 16 clocks)
// Notes: Watchdog waits keep a margin of less than one millisecond tick (16 clocks) either way; fault waits keep more than 16 clocks
`timescale 1ns/1ns
module test_esm_excitation;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic link_up = 1'b1;
  logic signed [31:0] current_loop_command = 32'sh0;
  logic [31:0] drive_peak_current = 32'h0000_1388;
  logic [31:0] motor_peak_current = 32'h0000_0fa0;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff;
  logic reg_wr, reg_rd, reg_rd_valid_ff, instability_fault_ff;
  logic signed [31:0] exc_current_ff, exc_velocity_ff, v;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  esm_excitation #(.SAMPLE_CYCLES(4), .MS_CYCLES(16)) i_esm_excitation (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .reg_rd_valid_ff(reg_rd_valid_ff), .link_up(link_up), .current_loop_command(current_loop_command),
    .drive_peak_current(drive_peak_current), .motor_peak_current(motor_peak_current),
    .exc_current_ff(exc_current_ff), .exc_velocity_ff(exc_velocity_ff), .instability_fault_ff(instability_fault_ff));
  esm_host_model i_esm_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reg_rd_valid_ff(reg_rd_valid_ff));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input logic [15:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    i_esm_host_model.rd(a, r);
    chk(n, r, e);
  endtask : rc
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic wr(input logic [15:0] a, input logic [31:0] dd);
    i_esm_host_model.wr(a, dd);
  endtask : wr

  task automatic t_reset_values();
    rc(16'h002c, 32'h0, "inject_reset");
    rc(16'h002e, 32'h0, "mode_reset");
    rc(16'h0512, 32'h0, "thresh_reset");
    rc(16'h0100, 32'h0, "unmapped_read");
  endtask : t_reset_values
  task automatic t_offset();
    wr(16'h002c, 32'h3);
    rc(16'h002c, 32'h0, "inject_refused");
    wr(16'h002c, 32'h1);
    wr(16'h002e, 32'h4);
    wt(2);
    chk("offset_cur", exc_current_ff, 32'd200);
    chk("offset_vel", exc_velocity_ff, 32'h0);
    wr(16'h002e, 32'h6);
    rc(16'h002e, 32'h4, "mode_refused");
    wr(16'h002e, 32'h0);
    wt(2);
    chk("none_out", {exc_current_ff | exc_velocity_ff}, 32'h0);
  endtask : t_offset
  task automatic t_waves();
    int cnt;
    wr(16'h0034, 32'd100);
    wr(16'h0032, 32'h4);
    wr(16'h002e, 32'h1);
    wt(8);
    cnt = 0;
    for (int i = 0; i < 16; i++) begin
      v = exc_current_ff;
      chk("prb_level", 32'(v == 200 || v == -200), 32'h1);
      cnt += (v < 0) ? 1 : 0;
      wt(4);
    end
    chk("prb_toggles", 32'(cnt > 0 && cnt < 16), 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = exc_current_ff;
      wt(64);
      chk("prb_period", exc_current_ff, v);
    end
    wr(16'h002c, 32'h2);
    wt(2);
    chk("vel_level", 32'(exc_velocity_ff == 100 || exc_velocity_ff == -100), 32'h1);
    chk("vel_cur_off", exc_current_ff, 32'h0);
    wr(16'h002c, 32'h1);
    wr(16'h002e, 32'h3);
    for (int i = 0; i < 30; i++) begin
      wt(1);
      chk("noise_range", 32'(exc_current_ff <= 200 && exc_current_ff >= -200), 32'h1);
    end
    wr(16'h0028, 32'd9000);
    rc(16'h0028, 32'h0000_1f40, "freq_clamp");
    wr(16'h0028, 32'd4000);
    wr(16'h002e, 32'h2);
    cnt = 0;
    for (int i = 0; i < 8; i++) begin
      wt(4);
      chk("sine_range", 32'(exc_current_ff <= 200 && exc_current_ff >= -200), 32'h1);
      cnt += (exc_current_ff > 150) ? 1 : 0;
    end
    chk("sine_peak", 32'(cnt > 0), 32'h1);
  endtask : t_waves
  task automatic t_watchdog();
    wr(16'h002e, 32'h1);
    wt(80);
    rc(16'h002e, 32'h1, "wd_off_hold");
    wr(16'h0030, 32'h3);
    wr(16'h002e, 32'h1);
    wt(20);
    rc(16'h002e, 32'h1, "wd_early");
    wr(16'h002e, 32'h1);
    wt(28);
    rc(16'h002e, 32'h1, "wd_refresh");
    wt(20);
    rc(16'h002e, 32'h0, "wd_expire");
    wr(16'h0030, 32'h0);
    wr(16'h002e, 32'h2);
    link_up = 1'b0;
    wt(1);
    link_up = 1'b1;
    rc(16'h002e, 32'h0, "link_down");
  endtask : t_watchdog
  task automatic t_fault();
    wr(16'h0512, 32'h0000_2710);
    rc(16'h0512, 32'h0000_0fa0, "thresh_max");
    wr(16'h0512, 32'h0);
    rc(16'h0512, 32'h1, "thresh_min");
    wr(16'h0512, 32'd100);
    wr(16'h0510, 32'd70000);
    rc(16'h0510, 32'h0000_ea60, "limit_max");
    wr(16'h0510, 32'd3);
    current_loop_command = 32'sd500;
    wr(16'h002e, 32'h5);
    wt(20);
    chk("fault_early", {31'h0, instability_fault_ff}, 32'h0);
    wt(60);
    chk("fault_set", {31'h0, instability_fault_ff}, 32'h1);
    rc(16'h0600, 32'h1, "fault_status");
    current_loop_command = 32'sh0;
    wr(16'h002e, 32'h0);
    wr(16'h0600, 32'h0);
    wr(16'h002e, 32'h5);
    current_loop_command = -32'sd500;
    wt(20);
    chk("acc_cleared", {31'h0, instability_fault_ff}, 32'h0);
  endtask : t_fault

  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    wt(5);
    reset_n = 1'b1;
    t_reset_values();
    t_offset();
    t_waves();
    t_watchdog();
    t_fault();
    conclude();
  end
endmodule : test_esm_excitation
